// [dmem_banked.sv]
// banked data memory: direct and indirect addressing, mirrored sfrs, bank-4 ram
// Behaviour
// - 464 bytes general ram in total
// - sfr and ram share 9-bit space
// - upper 16 bytes common to all banks
// - frequent sfrs mirrored in every bank
// - sfrs at low offsets, ram above
// - direct: bank bits form address bits 8,7
// - status bits 6..5 pick bank 0..3
// - indirect: bank bit plus 8-bit pointer
// - indirect port stores nothing, redirects
// - pointer 8-bit, resets zero, all banks
// - bank-4 ram only via its pointer
// - bank-4 port at same offset, no storage
// - bank-4 pointer bank 0 only, resets zero
// - status bit 7 picks banks 0/1 or 2/3
`timescale 1ns/1ps
module dmem_banked #(
    parameter int MAIN_BYTES  = 336,
    parameter int BANK4_DEPTH = 128
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    // cpu access
    input  wire dmem_pkg::cpu_req_t req,
    output logic [7:0]              rdata,
    // status and pointers as seen by the core
    output logic [7:0]              status_value,
    output logic [7:0]              indirect_pointer,
    output logic [7:0]              bank4_pointer,
    // other sfr accesses handed back to the core
    output logic                    sfr_sel,
    output logic [8:0]              sfr_addr,
    input  wire logic [7:0]         sfr_rdata
);
    import dmem_pkg::*;

    logic [7:0] status_reg, status_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] ptr4_reg, ptr4_next;
    logic [7:0] main_mem [MAIN_BYTES];
    logic [7:0] bank4_mem [BANK4_DEPTH];
    logic [7:0] rdata_reg, rdata_next;

    logic [8:0] direct_addr;
    logic [8:0] eff_addr;
    logic       via_indirect;
    logic       via_bank4;
    decode_t    dec;

    // true when the sfr offset is mirrored across all four banks
    function automatic logic is_mirror(input logic [6:0] o);
        return o == OFF_INDIRECT_PORT || o == 7'h02 || o == OFF_STATUS
            || o == OFF_INDIRECT_PTR || o == OFF_BANK4_PORT
            || o == 7'h0a || o == 7'h0b;
    endfunction : is_mirror

    always_comb begin
        direct_addr  = {status_reg[STAT_BANK_HI], status_reg[STAT_BANK_LO], req.operand};
        via_bank4    = req.operand == OFF_BANK4_PORT;
        via_indirect = req.operand == OFF_INDIRECT_PORT;
        eff_addr     = via_indirect ? {status_reg[STAT_IND_BANK], ptr_reg} : direct_addr;
    end

    dmem_decode u_decode (
        .eff_addr     (eff_addr),
        .bank4_access (via_bank4),
        .bank4_ptr    (ptr4_reg),
        .result       (dec)
    );

    // a mirrored sfr reached via the pointer collapses to its bank-0 copy
    logic [6:0] sfr_offs;
    logic       sfr_mirror;
    logic       hit_status, hit_ptr, hit_ptr4;
    always_comb begin
        sfr_offs   = dec.eff_addr[6:0];
        sfr_mirror = is_mirror(sfr_offs);
        hit_status = dec.target == TGT_SFR && sfr_offs == OFF_STATUS;
        hit_ptr    = dec.target == TGT_SFR && sfr_offs == OFF_INDIRECT_PTR;
        hit_ptr4   = dec.target == TGT_SFR && dec.eff_addr == {2'b00, OFF_BANK4_PTR};
    end

    always_comb begin
        status_next = status_reg;
        ptr_next    = ptr_reg;
        ptr4_next   = ptr4_reg;
        rdata_next  = 8'h00;
        if (req.wr) begin
            if (hit_status) status_next = req.wdata;
            if (hit_ptr) ptr_next = req.wdata;
            if (hit_ptr4) ptr4_next = req.wdata;
        end
        if (req.rd) begin
            case (dec.target)
                TGT_MAIN:  rdata_next = main_mem[dec.ram_index];
                TGT_BANK4: rdata_next = bank4_mem[dec.ram_index[6:0]];
                TGT_SFR: begin
                    if (hit_status) rdata_next = status_reg;
                    else if (hit_ptr) rdata_next = ptr_reg;
                    else if (hit_ptr4) rdata_next = ptr4_reg;
                    // the ports themselves read zero when the indirect pointer selects either one
                    else if (sfr_offs == OFF_INDIRECT_PORT || sfr_offs == OFF_BANK4_PORT)
                        rdata_next = 8'h00;
                    else rdata_next = sfr_rdata;
                end
                default:   rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_reg <= STATUS_RESET;
            ptr_reg    <= PTR_RESET;
            ptr4_reg   <= PTR_RESET;
            rdata_reg  <= 8'h00;
        end else begin
            status_reg <= status_next;
            ptr_reg    <= ptr_next;
            ptr4_reg   <= ptr4_next;
            rdata_reg  <= rdata_next;
        end
    end

    // ram arrays carry no reset, like real sram
    // ram storage
    always_ff @(posedge core_clk) begin
        if (!reset && req.wr && dec.target == TGT_MAIN) begin
            main_mem[dec.ram_index] <= req.wdata;
        end
        if (!reset && req.wr && dec.target == TGT_BANK4) begin
            bank4_mem[dec.ram_index[6:0]] <= req.wdata;
        end
    end

    always_comb begin
        rdata            = rdata_reg;
        status_value     = status_reg;
        indirect_pointer = ptr_reg;
        bank4_pointer    = ptr4_reg;
        // other sfrs pass out; bank-0 address for mirrored ones
        sfr_sel  = dec.target == TGT_SFR && !hit_status && !hit_ptr && !hit_ptr4
                   && sfr_offs != OFF_INDIRECT_PORT && sfr_offs != OFF_BANK4_PORT
                   && (req.rd || req.wr);
        sfr_addr = sfr_mirror ? {2'b00, sfr_offs} : dec.eff_addr;
    end
endmodule : dmem_banked

// [dmem_pkg.sv]
// shared constants and carriers for the banked data memory decoder
package dmem_pkg;
    localparam int ADDR_W          = 9;
    localparam int DATA_W          = 8;
    localparam int OFFS_W          = 7;
    // sfr offsets inside a bank
    localparam logic [6:0] OFF_INDIRECT_PORT = 7'h00;
    localparam logic [6:0] OFF_STATUS        = 7'h03;
    localparam logic [6:0] OFF_INDIRECT_PTR  = 7'h04;
    localparam logic [6:0] OFF_BANK4_PORT    = 7'h09;
    localparam logic [6:0] OFF_BANK4_PTR     = 7'h0d;
    localparam logic [6:0] SFR_TOP           = 7'h1f;
    localparam logic [6:0] COMMON_BASE       = 7'h70;
    // general ram layout
    localparam int BANK_RAM_BYTES  = 80;
    localparam int COMMON_BYTES    = 16;
    localparam int BANK4_BYTES     = 128;
    localparam int NUM_BANKS       = 4;
    localparam int TOTAL_RAM       = NUM_BANKS * BANK_RAM_BYTES + COMMON_BYTES + BANK4_BYTES;
    localparam logic [6:0] RAM_BASE          = 7'h20;
    // status field positions
    localparam int STAT_IND_BANK   = 7;
    localparam int STAT_BANK_HI    = 6;
    localparam int STAT_BANK_LO    = 5;
    // reset values
    localparam logic [7:0] PTR_RESET         = 8'h00;
    localparam logic [7:0] STATUS_RESET      = 8'h00;

    typedef enum logic [1:0] {
        TGT_NONE   = 2'b00,
        TGT_MAIN   = 2'b01,
        TGT_BANK4  = 2'b10,
        TGT_SFR    = 2'b11
    } target_t;

    // one cpu access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] operand;
        logic [7:0] wdata;
    } cpu_req_t;

    // resolved physical access
    typedef struct packed {
        target_t    target;
        logic [8:0] eff_addr;
        logic [8:0] ram_index;
    } decode_t;
endpackage : dmem_pkg

// [dmem_decode.sv]
// address decode from 9-bit effective address to physical target
`timescale 1ns/1ps
module dmem_decode (
    // inputs
    input  wire logic [8:0]         eff_addr,
    input  wire logic               bank4_access,
    input  wire logic [7:0]         bank4_ptr,
    // result
    output dmem_pkg::decode_t       result
);
    import dmem_pkg::*;

    logic [6:0] offs;
    logic [1:0] bank;

    always_comb begin
        offs   = eff_addr[6:0];
        bank   = eff_addr[8:7];
        result = '{target: TGT_NONE, eff_addr: eff_addr, ram_index: 9'h000};
        if (bank4_access) begin
            result.target    = TGT_BANK4;
            result.ram_index = {2'b00, bank4_ptr[6:0]};
        end else if (offs >= COMMON_BASE) begin
            result.target    = TGT_MAIN;
            result.ram_index = 9'(NUM_BANKS * BANK_RAM_BYTES) + {5'h00, offs[3:0]};
        end else if (offs >= RAM_BASE) begin
            result.target    = TGT_MAIN;
            // widen before the product: bank 3 times 80 overflows seven bits
            result.ram_index = 9'(bank) * 9'(BANK_RAM_BYTES) + {2'b00, offs - RAM_BASE};
        end else begin
            result.target = TGT_SFR;
        end
    end
endmodule : dmem_decode

// [dmem_banked_asserts.sv]
// port checker for the banked data memory
`timescale 1ns/1ps
module dmem_banked_asserts (
    // watched ports
    input wire logic               core_clk,
    input wire logic               reset,
    input wire dmem_pkg::cpu_req_t req,
    input wire logic [7:0]         rdata,
    input wire logic [7:0]         status_value,
    input wire logic [7:0]         indirect_pointer,
    input wire logic [7:0]         bank4_pointer,
    input wire logic               sfr_sel,
    input wire logic [8:0]         sfr_addr,
    input wire logic [7:0]         sfr_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ptr_write_a: assert property (req.wr && req.operand == 7'h04 |=>
        indirect_pointer == $past(req.wdata)) else $error("pointer write lost");
    b4_write_a: assert property (req.wr && req.operand == 7'h0d && status_value[6:5] == 2'b00
        |=> bank4_pointer == $past(req.wdata)) else $error("bank4 pointer write lost");
    b4_guard_a: assert property (req.wr && req.operand == 7'h0d && status_value[6:5] != 2'b00
        |=> $stable(bank4_pointer)) else $error("bank4 pointer hit outside bank 0");
    bank_bits_a: assert property (req.wr && req.operand == 7'h03 |=>
        status_value[7:5] == $past(req.wdata[7:5])) else $error("bank bits not stored");
    ptr_mirror_a: assert property (req.rd && req.operand == 7'h04 |=>
        rdata == $past(indirect_pointer)) else $error("pointer read wrong");
    stat_mirror_a: assert property (req.rd && req.operand == 7'h03 |=>
        rdata == $past(status_value)) else $error("status read wrong");
    direct_sfr_a: assert property ((req.rd || req.wr) && req.operand inside {7'h1c, 7'h1d}
        |-> sfr_sel && sfr_addr == {status_value[6:5], req.operand}) else $error("direct addr");
    ram_no_sfr_a: assert property ((req.rd || req.wr) && req.operand >= 7'h20
        |-> !sfr_sel) else $error("ram access left as sfr");
    sfr_data_a: assert property (req.rd && sfr_sel |=> rdata == $past(sfr_rdata))
        else $error("sfr read data lost");
    cover property (req.wr && req.operand == 7'h0d);
    cover property (req.rd && sfr_sel);
    cover property (req.rd && req.operand == 7'h00 && status_value[7]);
endmodule : dmem_banked_asserts

bind dmem_banked dmem_banked_asserts i_dmem_banked_asserts (.core_clk(core_clk),
    .reset(reset), .req(req), .rdata(rdata), .status_value(status_value),
    .indirect_pointer(indirect_pointer), .bank4_pointer(bank4_pointer),
    .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata));

// [sfr_core_model.sv]
// core-side sfr responder for accesses handed back by the decoder
`timescale 1ns/1ps
module sfr_core_model (
    // access
    input wire logic       core_clk,
    input wire logic       sfr_sel,
    input wire logic [8:0] sfr_addr,
    // answer
    output logic [7:0]     sfr_rdata
);
    logic [7:0] churn_reg = 8'h00;
    // unselected: moving pattern so stale data never matches
    always_ff @(posedge core_clk) churn_reg <= churn_reg + 8'h3b;
    assign sfr_rdata = sfr_sel ? (sfr_addr[7:0] ^ 8'h5a) : churn_reg;
endmodule : sfr_core_model

// [test_banked_data_memory_addressing.sv]
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module test_banked_data_memory_addressing;
    import dmem_pkg::*;
    logic core_clk, reset, sfr_sel;
    cpu_req_t req;
    logic [7:0] rdata, status_value, indirect_pointer, bank4_pointer, sfr_rdata;
    logic [8:0] sfr_addr;
    int miscompares = 0;
    int n_checks = 0;
    dmem_banked i_dmem_banked (.core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata),
        .status_value(status_value), .indirect_pointer(indirect_pointer),
        .bank4_pointer(bank4_pointer), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
        .sfr_rdata(sfr_rdata));
    sfr_core_model i_sfr_core_model (.core_clk(core_clk), .sfr_sel(sfr_sel),
        .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // one access; rdata sampled just after the taking edge
    task automatic acc(input logic r, input logic w, input logic [6:0] op, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{rd: r, wr: w, operand: op, wdata: d};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask : acc
    task automatic put(input logic [6:0] op, input logic [7:0] d);
        acc(1'b0, 1'b1, op, d);
    endtask : put
    task automatic get(input logic [6:0] op, input logic [7:0] exp, input string what);
        acc(1'b1, 1'b0, op, 8'h00);
        chk(what, exp, rdata);
    endtask : get
    task automatic s_reset;
        get(7'h04, 8'h00, "ptr");
        chk("b4ptr", 8'h00, bank4_pointer);
    endtask : s_reset
    task automatic s_direct;
        put(7'h04, 8'h44);
        chk("ptr out", 8'h44, indirect_pointer);
        for (int b = 0; b < 4; b++) begin
            put(7'h03, {1'b0, b[1:0], 5'h00});
            chk("bank bits", {1'b0, b[1:0], 5'h00}, status_value);
            put(7'h20, 8'h10 + b[7:0]);
        end
        put(7'h7f, 8'h99);
        for (int b = 0; b < 4; b++) begin
            put(7'h03, {1'b0, b[1:0], 5'h00});
            get(7'h20, 8'h10 + b[7:0], "ram");
            get(7'h7f, 8'h99, "common");
            get(7'h04, 8'h44, "ptr mirror");
            get(7'h1d, {b[0], 7'h1d} ^ 8'h5a, "sfr");
        end
    endtask : s_direct
    task automatic s_indirect;
        put(7'h03, 8'h00);
        put(7'h04, 8'ha0);
        get(7'h00, 8'h11, "ind bank1");
        put(7'h03, 8'h80);
        put(7'h00, 8'h77);
        put(7'h03, 8'h60);
        get(7'h20, 8'h77, "ind bank3");
        put(7'h03, 8'h80);
        put(7'h04, 8'h1c);
        get(7'h00, 8'h46, "ind sfr");
        put(7'h04, 8'h00);
        get(7'h00, 8'h00, "port to port");
    endtask : s_indirect
    task automatic s_bank4;
        put(7'h03, 8'h00);
        put(7'h0d, 8'h05);
        put(7'h09, 8'h5a);
        put(7'h03, 8'h40);
        get(7'h09, 8'h5a, "b4 port");
        put(7'h03, 8'h00);
        put(7'h0d, 8'h7f);
        put(7'h09, 8'ha5);
        get(7'h09, 8'ha5, "b4 top");
        put(7'h03, 8'h20);
        put(7'h0d, 8'h33);
        chk("b4ptr", 8'h7f, bank4_pointer);
    endtask : s_bank4
    initial begin
        reset = 1'b1;
        req = '0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        s_reset();
        s_direct();
        s_indirect();
        s_bank4();
        wrap_up();
    end
    initial begin
        #25000;
        miscompares++;
        wrap_up();
    end
endmodule : test_banked_data_memory_addressing
